//--- rtl/cdtb_decode.sv
// Decoder for the first table base and related bits of a stage 1 context descriptor.
// Assumes descriptor and effective settings held stable in the cycle req_valid is high.
// Function
// - First base is descriptor bits 115:68, shifted.
// - Clear base bits below start-level alignment.
// - 64KB granule with 52-bit output: 64-byte alignment.
// - Walk disable set: base ignored, never illegal.
// - Base beyond effective output size is illegal.
// - Granule below 64KB with base over 48 bits: illegal.
// - 52-bit base accepted only with 64KB granule.
// - Earliest version: bits 115:112 read as zero.
// - Bit 124 enables hardware use of bit 59.
// - Hardware-use bits ignored without support or disable.
// - Bits 125-127 steer final bits 60-62.
// - Earliest version: hardware-use bits read as zero.
// - Bit 128 sets second table fetch security.
// - Bit 128 reads zero in EL2 or EL3.
// - Zero secure, one non-secure; secure streams only.
// - Bit 65 disables hierarchical attributes when one.
`timescale 1ns/100ps
`include "cdtb_regs.svh"

module cdtb_decode (
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    input  wire logic                     req_valid,
    input  wire logic [`CDTB_DESC_W-1:0]  context_descriptor,
    input  wire logic                     first_walk_disable,
    input  wire cdtb_pkg::cdtb_granule_t  first_granule_select,
    input  wire logic [2:0]               output_addr_size,
    input  wire logic [`CDTB_ALIGN_W-1:0] start_align_bits,
    input  wire logic                     page_hw_attr_support,
    input  wire logic                     arch_v30,
    input  wire logic                     secure_stream,
    input  wire cdtb_pkg::cdtb_world_t    stream_translation_world,
    output logic                          req_ready,
    output logic                          resp_valid,
    output logic                          desc_illegal,
    output logic                          config_error,
    output logic                          walk_enable,
    output logic      [`CDTB_ADDR_W-1:0]  first_table_base,
    output logic                          hw_use_bit59_ctrl,
    output logic                          hw_use_bit60_ctrl,
    output logic                          hw_use_bit61_ctrl,
    output logic                          hw_use_bit62_ctrl,
    output logic                          first_hier_attr_disable,
    output logic                          first_walk_security_attr,
    output logic                          second_walk_security_attr
);
    import cdtb_pkg::*;

    // *****************************************************************
    // Capture stage
    // *****************************************************************
    cdtb_state_t              state;
    cdtb_state_t              next_state;
    logic [`CDTB_BASE_W-1:0]  cap_base;
    logic [`CDTB_BASE_W-1:0]  next_cap_base;
    logic [`CDTB_ALIGN_W-1:0] cap_align;
    logic [`CDTB_ALIGN_W-1:0] next_cap_align;
    cdtb_granule_t            cap_gran;
    cdtb_granule_t            next_cap_gran;
    logic [2:0]               cap_oas;
    logic [2:0]               next_cap_oas;
    logic                     cap_v30;
    logic                     next_cap_v30;
    logic                     cap_epd;
    logic                     next_cap_epd;
    logic [`CDTB_HWU_W-1:0]   cap_hwu;
    logic [`CDTB_HWU_W-1:0]   next_cap_hwu;
    logic                     cap_had;
    logic                     next_cap_had;
    logic                     cap_ns0;
    logic                     next_cap_ns0;
    logic                     cap_ns1;
    logic                     next_cap_ns1;

    function automatic logic high_world(input cdtb_world_t w);
        high_world = (w == CDTB_WORLD_EL2) || (w == CDTB_WORLD_EL2_E2H)
                  || (w == CDTB_WORLD_EL3);
    endfunction

    always_comb begin
        next_state     = state;
        next_cap_base  = cap_base;
        next_cap_align = cap_align;
        next_cap_gran  = cap_gran;
        next_cap_oas   = cap_oas;
        next_cap_v30   = cap_v30;
        next_cap_epd   = cap_epd;
        next_cap_hwu   = cap_hwu;
        next_cap_had   = cap_had;
        next_cap_ns0   = cap_ns0;
        next_cap_ns1   = cap_ns1;
        unique case (state)
            CDTB_ST_IDLE: begin
                if (req_valid) begin
                    next_state     = CDTB_ST_EVAL;
                    next_cap_base  = context_descriptor[`CDTB_BASE_HI:`CDTB_BASE_LO];
                    next_cap_align = start_align_bits;
                    next_cap_gran  = first_granule_select;
                    next_cap_oas   = output_addr_size;
                    next_cap_v30   = arch_v30;
                    next_cap_epd   = first_walk_disable;
                    next_cap_had   = context_descriptor[`CDTB_HAD_FIRST_BIT];
                    next_cap_hwu   = '0;
                    if (page_hw_attr_support && next_cap_had && !arch_v30) begin
                        // Bits 124..127 steer bits 59..62 in order
                        next_cap_hwu = context_descriptor[`CDTB_HWU_LO +: `CDTB_HWU_W];
                    end
                    // Non-secure streams always fetch non-secure
                    next_cap_ns0 = secure_stream
                                 ? context_descriptor[`CDTB_NS_FIRST_BIT] : 1'b1;
                    next_cap_ns1 = 1'b1;
                    if (secure_stream) begin
                        next_cap_ns1 = high_world(stream_translation_world)
                                     ? 1'b0
                                     : context_descriptor[`CDTB_NS_SECOND_BIT];
                    end
                end
            end
            CDTB_ST_EVAL: begin
                next_state = CDTB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state     <= CDTB_ST_IDLE;
            cap_base  <= '0;
            cap_align <= '0;
            cap_gran  <= CDTB_GRAN_4K;
            cap_oas   <= `CDTB_OAS_32;
            cap_v30   <= 1'b0;
            cap_epd   <= 1'b0;
            cap_hwu   <= '0;
            cap_had   <= 1'b0;
            cap_ns0   <= 1'b1;
            cap_ns1   <= 1'b1;
        end else begin
            state     <= next_state;
            cap_base  <= next_cap_base;
            cap_align <= next_cap_align;
            cap_gran  <= next_cap_gran;
            cap_oas   <= next_cap_oas;
            cap_v30   <= next_cap_v30;
            cap_epd   <= next_cap_epd;
            cap_hwu   <= next_cap_hwu;
            cap_had   <= next_cap_had;
            cap_ns0   <= next_cap_ns0;
            cap_ns1   <= next_cap_ns1;
        end
    end

    // *****************************************************************
    // Base check
    // *****************************************************************
    logic [`CDTB_ADDR_W-1:0] chk_base;
    logic                    chk_bad;

    cdtb_base_check u_base_check (
        .raw_base     (cap_base),
        .align_bits   (cap_align),
        .granule      (cap_gran),
        .oas_code     (cap_oas),
        .arch_v30     (cap_v30),
        .aligned_base (chk_base),
        .out_of_range (chk_bad)
    );

    // *****************************************************************
    // Result stage
    // *****************************************************************
    logic                    next_req_ready;
    logic                    next_resp_valid;
    logic                    next_desc_illegal;
    logic                    next_config_error;
    logic                    next_walk_enable;
    logic [`CDTB_ADDR_W-1:0] next_first_table_base;
    logic [`CDTB_HWU_W-1:0]  next_hwu;
    logic                    next_had;
    logic                    next_ns0;
    logic                    next_ns1;
    logic                    eval;

    always_comb begin
        eval                  = (state == CDTB_ST_EVAL);
        next_req_ready        = (next_state == CDTB_ST_IDLE);
        next_resp_valid       = eval;
        next_desc_illegal     = desc_illegal;
        next_config_error     = 1'b0;
        next_walk_enable      = walk_enable;
        next_first_table_base = first_table_base;
        next_hwu = {hw_use_bit62_ctrl, hw_use_bit61_ctrl,
                    hw_use_bit60_ctrl, hw_use_bit59_ctrl};
        next_had = first_hier_attr_disable;
        next_ns0 = first_walk_security_attr;
        next_ns1 = second_walk_security_attr;
        if (eval) begin
            next_hwu = cap_hwu;
            next_had = cap_had;
            next_ns0 = cap_ns0;
            next_ns1 = cap_ns1;
            if (cap_epd) begin
                next_desc_illegal     = 1'b0;
                next_walk_enable      = 1'b0;
                next_first_table_base = '0;
            end else begin
                next_desc_illegal     = chk_bad;
                next_config_error     = chk_bad;
                next_walk_enable      = !chk_bad;
                next_first_table_base = chk_base;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            req_ready                 <= 1'b0;
            resp_valid                <= 1'b0;
            desc_illegal              <= 1'b0;
            config_error              <= 1'b0;
            walk_enable               <= 1'b0;
            first_table_base          <= '0;
            hw_use_bit59_ctrl         <= 1'b0;
            hw_use_bit60_ctrl         <= 1'b0;
            hw_use_bit61_ctrl         <= 1'b0;
            hw_use_bit62_ctrl         <= 1'b0;
            first_hier_attr_disable   <= 1'b0;
            first_walk_security_attr  <= 1'b1;
            second_walk_security_attr <= 1'b1;
        end else begin
            req_ready                 <= next_req_ready;
            resp_valid                <= next_resp_valid;
            desc_illegal              <= next_desc_illegal;
            config_error              <= next_config_error;
            walk_enable               <= next_walk_enable;
            first_table_base          <= next_first_table_base;
            hw_use_bit59_ctrl         <= next_hwu[0];
            hw_use_bit60_ctrl         <= next_hwu[1];
            hw_use_bit61_ctrl         <= next_hwu[2];
            hw_use_bit62_ctrl         <= next_hwu[3];
            first_hier_attr_disable   <= next_had;
            first_walk_security_attr  <= next_ns0;
            second_walk_security_attr <= next_ns1;
        end
    end

    // *****************************************************************
    // Assertions
    // *****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic take;
    assign take = req_valid && state == CDTB_ST_IDLE;

    sequence s_take;
        take;
    endsequence

    sequence s_answer;
        !resp_valid ##1 resp_valid;
    endsequence

    a_resp_timing: assert property (s_take |-> ##1 s_answer)
        else $error("Answer not two cycles after request");

    a_base_field: assert property (take && !first_walk_disable && !arch_v30
        && start_align_bits <= `CDTB_ALIGN_52 && first_granule_select == CDTB_GRAN_64K
        && output_addr_size == `CDTB_OAS_52 |-> ##2
        first_table_base == {$past(context_descriptor[`CDTB_BASE_HI:`CDTB_BASE_LO+2], 2),
                             6'h00})
        else $error("Base field not placed at bit four");

    a_base_aligned: assert property (resp_valid && walk_enable |->
        (first_table_base & ~({`CDTB_ADDR_W{1'b1}} << $past(start_align_bits, 2))) == '0)
        else $error("Base not aligned");

    a_align_64: assert property (take && !first_walk_disable
        && first_granule_select == CDTB_GRAN_64K && output_addr_size == `CDTB_OAS_52
        |-> ##2 first_table_base[5:0] == 6'h00)
        else $error("Base not 64-byte aligned");

    a_walk_off: assert property (take && first_walk_disable |->
        ##2 !desc_illegal && !config_error && !walk_enable)
        else $error("Disabled walk flagged or enabled");

    a_narrow_range: assert property (take && !first_walk_disable
        && first_granule_select != CDTB_GRAN_64K && !arch_v30
        && |context_descriptor[`CDTB_BASE_HI:`CDTB_BASE_HI-3] |-> ##2 desc_illegal)
        else $error("Wide base with small granule accepted");

    a_oas_range: assert property (take && !first_walk_disable
        && output_addr_size == `CDTB_OAS_32 && |context_descriptor[`CDTB_BASE_HI:96]
        |-> ##2 desc_illegal && config_error)
        else $error("Base beyond output size accepted");

    a_v30_top: assert property (resp_valid && $past(arch_v30, 2) |->
        first_table_base[`CDTB_ADDR_W-1:`CDTB_NARROW_TOP] == 4'h0)
        else $error("Top base bits kept in earliest version");

    a_hwu_gate: assert property (take && (!page_hw_attr_support || arch_v30
        || !context_descriptor[`CDTB_HAD_FIRST_BIT]) |-> ##2
        !(hw_use_bit59_ctrl || hw_use_bit60_ctrl || hw_use_bit61_ctrl || hw_use_bit62_ctrl))
        else $error("Hardware-use bits leaked");

    a_hwu_pass: assert property (take && page_hw_attr_support && !arch_v30
        && context_descriptor[`CDTB_HAD_FIRST_BIT] |-> ##2
        {hw_use_bit62_ctrl, hw_use_bit61_ctrl, hw_use_bit60_ctrl, hw_use_bit59_ctrl}
        == $past(context_descriptor[`CDTB_HWU_LO +: `CDTB_HWU_W], 2))
        else $error("Hardware-use bits misrouted");

    a_second_sec: assert property (take && secure_stream
        && high_world(stream_translation_world) |-> ##2 !second_walk_security_attr)
        else $error("Second attribute not read as zero");

    a_err_blocks: assert property (config_error |-> desc_illegal && !walk_enable)
        else $error("Error without blocking walk");

endmodule // cdtb_decode

//--- rtl/cdtb_regs.svh
// Field positions, encodings and alignment figures of the descriptor decoder.
// Assumes inclusion by bare name from design and bench files.
`ifndef CDTB_REGS_SVH
`define CDTB_REGS_SVH

`define CDTB_DESC_W        129
`define CDTB_ADDR_W        52
`define CDTB_ALIGN_W       6
`define CDTB_BASE_HI       115
`define CDTB_BASE_LO       68
`define CDTB_BASE_LSB      4
`define CDTB_BASE_W        48
`define CDTB_NS_FIRST_BIT  64
`define CDTB_HAD_FIRST_BIT 65
`define CDTB_HWU_LO        124
`define CDTB_HWU_W         4
`define CDTB_NS_SECOND_BIT 128
`define CDTB_NARROW_TOP    48
`define CDTB_ALIGN_52      6'h06
`define CDTB_OAS_32        3'h0
`define CDTB_OAS_36        3'h1
`define CDTB_OAS_40        3'h2
`define CDTB_OAS_42        3'h3
`define CDTB_OAS_44        3'h4
`define CDTB_OAS_48        3'h5
`define CDTB_OAS_52        3'h6

`endif

//--- rtl/cdtb_pkg.sv
// Types shared by the descriptor decoder and its base checker.
// Assumes nothing of its surroundings.
package cdtb_pkg;

    typedef enum logic [1:0] {
        CDTB_GRAN_4K,
        CDTB_GRAN_16K,
        CDTB_GRAN_64K
    } cdtb_granule_t;

    typedef enum logic [2:0] {
        CDTB_WORLD_NS_EL1,
        CDTB_WORLD_SECURE,
        CDTB_WORLD_EL2_E2H,
        CDTB_WORLD_EL2,
        CDTB_WORLD_EL3
    } cdtb_world_t;

    typedef enum logic {
        CDTB_ST_IDLE,
        CDTB_ST_EVAL
    } cdtb_state_t;

endpackage

//--- rtl/cdtb_base_check.sv
// Combinational alignment and range check of the first table base.
// Assumes effective size and granule values settled by the caller.
`timescale 1ns/100ps
`include "cdtb_regs.svh"

module cdtb_base_check (
    input  wire logic [`CDTB_BASE_W-1:0]  raw_base,
    input  wire logic [`CDTB_ALIGN_W-1:0] align_bits,
    input  wire cdtb_pkg::cdtb_granule_t  granule,
    input  wire logic [2:0]               oas_code,
    input  wire logic                     arch_v30,
    output logic      [`CDTB_ADDR_W-1:0]  aligned_base,
    output logic                          out_of_range
);
    import cdtb_pkg::*;

    // *****************************************************************
    // Helpers
    // *****************************************************************
    function automatic logic [5:0] oas_width(input logic [2:0] code);
        unique case (code)
            `CDTB_OAS_32: oas_width = 6'h20;
            `CDTB_OAS_36: oas_width = 6'h24;
            `CDTB_OAS_40: oas_width = 6'h28;
            `CDTB_OAS_42: oas_width = 6'h2A;
            `CDTB_OAS_44: oas_width = 6'h2C;
            `CDTB_OAS_48: oas_width = 6'h30;
            default:      oas_width = 6'h34;
        endcase
    endfunction

    function automatic logic above(input logic [`CDTB_ADDR_W-1:0] a,
                                   input logic [5:0] top);
        logic [`CDTB_ADDR_W-1:0] shifted;
        shifted = a >> top;
        above   = |shifted;
    endfunction

    // *****************************************************************
    // Check
    // *****************************************************************
    logic [`CDTB_ADDR_W-1:0]  full;
    logic [`CDTB_ADDR_W-1:0]  mask;
    logic [`CDTB_ALIGN_W-1:0] eff_align;
    logic                     g64;

    always_comb begin
        g64  = (granule == CDTB_GRAN_64K);
        full = {raw_base, {`CDTB_BASE_LSB{1'b0}}};
        if (arch_v30) begin
            full[`CDTB_ADDR_W-1:`CDTB_NARROW_TOP] = '0;
        end
        eff_align = align_bits;
        if (g64 && oas_code >= `CDTB_OAS_52 && eff_align < `CDTB_ALIGN_52) begin
            eff_align = `CDTB_ALIGN_52;
        end
        mask         = {`CDTB_ADDR_W{1'b1}} << eff_align;
        aligned_base = full & mask;
        out_of_range = above(aligned_base, oas_width(oas_code))
                     || (!g64 && above(aligned_base, 6'(`CDTB_NARROW_TOP)));
    end

endmodule // cdtb_base_check

//--- verif/cdtb_desc_mem.sv
// Behavioural memory holding context descriptors for the decoder bench.
// Assumes a write port driven from the bench and a combinational read.
`timescale 1ns/100ps
`include "cdtb_regs.svh"

module cdtb_desc_mem (
    input  wire logic                    core_clk,
    input  wire logic                    wr_en,
    input  wire logic [2:0]              wr_idx,
    input  wire logic [`CDTB_DESC_W-1:0] wr_data,
    input  wire logic [2:0]              rd_idx,
    output logic      [`CDTB_DESC_W-1:0] rd_data
);
    logic [`CDTB_DESC_W-1:0] mem [8];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];
endmodule // cdtb_desc_mem

//--- verif/tb_cdtb_decode.sv
// Self-checking bench for the first table base decoder.
// Assumes the design files and the descriptor memory model compiled first.
`timescale 1ns/100ps
`include "cdtb_regs.svh"

module tb_cdtb_decode;
    import cdtb_pkg::*;
    // ****************
    // Signals
    // ****************
    logic                    core_clk = 1'b0;
    logic                    nrst     = 1'b0;
    logic                    req_valid = 1'b0;
    logic                    wr_en    = 1'b0;
    logic [2:0]              slot     = 3'h0;
    logic [`CDTB_DESC_W-1:0] wr_data  = '0;
    logic [`CDTB_DESC_W-1:0] desc;
    logic                    wd = 1'b0, pb = 1'b0, v3 = 1'b0, sc = 1'b0;
    cdtb_granule_t           gran = CDTB_GRAN_4K;
    cdtb_world_t             world = CDTB_WORLD_NS_EL1;
    logic [2:0]              oas = 3'h0;
    logic [5:0]              al  = 6'h00;
    logic                    rdy, rsp, ill, cfg, wen, had, ns0, ns1;
    logic [3:0]              hwu;
    logic [51:0]             base;
    int                      miscompares = 0;
    int                      check_count = 0;

    always #50 core_clk = ~core_clk;

    cdtb_desc_mem u_cdtb_desc_mem (.core_clk(core_clk), .wr_en(wr_en), .wr_idx(slot),
        .wr_data(wr_data), .rd_idx(slot), .rd_data(desc));

    cdtb_decode u_cdtb_decode (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid),
        .context_descriptor(desc), .first_walk_disable(wd), .first_granule_select(gran),
        .output_addr_size(oas), .start_align_bits(al), .page_hw_attr_support(pb),
        .arch_v30(v3), .secure_stream(sc), .stream_translation_world(world),
        .req_ready(rdy), .resp_valid(rsp), .desc_illegal(ill), .config_error(cfg),
        .walk_enable(wen), .first_table_base(base), .hw_use_bit59_ctrl(hwu[0]),
        .hw_use_bit60_ctrl(hwu[1]), .hw_use_bit61_ctrl(hwu[2]),
        .hw_use_bit62_ctrl(hwu[3]), .first_hier_attr_disable(had),
        .first_walk_security_attr(ns0), .second_walk_security_attr(ns1));

    // ****************
    // Tasks
    // ****************
    task automatic end_sim;
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic step;
        @(posedge core_clk);
        #10;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_vec(input string nm, input logic [51:0] e, input logic [51:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [`CDTB_DESC_W-1:0] mk(input logic [47:0] b, input logic [3:0] h,
        input logic hd, input logic n0, input logic n1);
        return {n1, h, 8'h00, b, 2'b00, hd, n0, 64'hA5A5_5A5A_C3C3_3C3C};
    endfunction

    // Stores the descriptor, issues one request and checks the answer two edges on
    task automatic req(input logic [`CDTB_DESC_W-1:0] d, input logic w_d,
        input cdtb_granule_t g, input logic [2:0] o, input logic [5:0] a, input logic p,
        input logic v, input logic s, input cdtb_world_t wl, input logic e_ill,
        input logic [51:0] e_base, input logic [3:0] e_hwu, input logic [1:0] e_ns);
        int n;
        n = 0;
        slot = slot + 3'h1;
        wr_data = d;
        wr_en = 1'b1;
        step();
        wr_en = 1'b0;
        chk_bit("resp_valid pulse end", 1'b0, rsp);
        chk_bit("config_error pulse end", 1'b0, cfg);
        wd = w_d; gran = g; oas = o; al = a; pb = p; v3 = v; sc = s; world = wl;
        while (rdy !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        chk_bit("req_ready before take", 1'b1, rdy);
        req_valid = 1'b1;
        step();
        req_valid = 1'b0;
        chk_bit("resp_valid early", 1'b0, rsp);
        chk_bit("req_ready after take", 1'b0, rdy);
        step();
        chk_bit("resp_valid", 1'b1, rsp);
        chk_bit("req_ready with answer", 1'b1, rdy);
        chk_bit("config_error", e_ill, cfg);
        chk_bit("desc_illegal", e_ill, ill);
        chk_bit("walk_enable", !e_ill && !w_d, wen);
        if (!e_ill) begin
            chk_vec("first_table_base", e_base, base);
        end
        chk_vec("hw_use", {48'h0, e_hwu}, {48'h0, hwu});
        chk_bit("first_hier_attr_disable", d[`CDTB_HAD_FIRST_BIT], had);
        chk_bit("first_walk_security_attr", e_ns[1], ns0);
        chk_bit("second_walk_security_attr", e_ns[0], ns1);
    endtask

    // ****************
    // Tests
    // ****************
    initial begin
        #(2000 * 100);
        miscompares++;
        end_sim();
    end

    initial begin
        logic [3:0] h;
        logic       e2;
        repeat (4) step();
        chk_bit("req_ready in reset", 1'b0, rdy);
        chk_bit("second attr in reset", 1'b1, ns1);
        nrst = 1'b1;
        step();
        req(mk(48'h00123456789F, 0, 0, 0, 0), 0, CDTB_GRAN_4K, 3'h6, 6'h0C, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 0, 52'h0012345678000, 4'h0, 2'b11);
        req(mk(48'h000000000FFF, 0, 0, 0, 0), 0, CDTB_GRAN_64K, 3'h6, 6'h03, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 0, 52'h000000000FFC0, 4'h0, 2'b11);
        req(mk(48'h000000000FFF, 0, 0, 0, 0), 0, CDTB_GRAN_64K, 3'h5, 6'h03, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 0, 52'h000000000FFF0, 4'h0, 2'b11);
        req(mk(48'h00000FFFFFFF, 0, 0, 0, 0), 0, CDTB_GRAN_4K, 3'h0, 6'h04, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 0, 52'h00000FFFFFFF0, 4'h0, 2'b11);
        req(mk(48'h000010000000, 0, 0, 0, 0), 0, CDTB_GRAN_4K, 3'h0, 6'h04, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 1, 52'h0, 4'h0, 2'b11);
        req(mk(48'h100000000000, 0, 0, 0, 0), 0, CDTB_GRAN_16K, 3'h6, 6'h0E, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 1, 52'h0, 4'h0, 2'b11);
        req(mk(48'h100000000000, 0, 0, 0, 0), 0, CDTB_GRAN_4K, 3'h6, 6'h0C, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 1, 52'h0, 4'h0, 2'b11);
        req(mk(48'h100000000000, 0, 0, 0, 0), 0, CDTB_GRAN_64K, 3'h6, 6'h10, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 0, 52'h1000000000000, 4'h0, 2'b11);
        req(mk(48'h100000000000, 0, 0, 0, 0), 0, CDTB_GRAN_64K, 3'h5, 6'h10, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 1, 52'h0, 4'h0, 2'b11);
        req(mk(48'hF00000001000, 4'hF, 1, 0, 0), 0, CDTB_GRAN_64K, 3'h6, 6'h10, 1, 1, 0,
            CDTB_WORLD_NS_EL1, 0, 52'h0000000010000, 4'h0, 2'b11);
        req(mk(48'hFFFFFFFFFFFF, 0, 0, 0, 0), 1, CDTB_GRAN_4K, 3'h0, 6'h0C, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 0, 52'h0, 4'h0, 2'b11);
        for (int i = 0; i < 4; i++) begin
            h = 4'h1 << i;
            req(mk(48'h000000000100, h, 1, 0, 0), 0, CDTB_GRAN_4K, 3'h6, 6'h0C, 1, 0, 0,
                CDTB_WORLD_NS_EL1, 0, 52'h0000000001000, h, 2'b11);
            req(mk(48'h000000000100, h, 1, 0, 0), 0, CDTB_GRAN_4K, 3'h6, 6'h0C, 0, 0, 0,
                CDTB_WORLD_NS_EL1, 0, 52'h0000000001000, 4'h0, 2'b11);
            req(mk(48'h000000000100, h, 0, 0, 0), 0, CDTB_GRAN_4K, 3'h6, 6'h0C, 1, 0, 0,
                CDTB_WORLD_NS_EL1, 0, 52'h0000000001000, 4'h0, 2'b11);
        end
        for (int k = 0; k < 5; k++) begin
            for (int n = 0; n < 2; n++) begin
                e2 = (k >= 2) ? 1'b0 : n[0];
                req(mk(48'h000000000100, 0, 0, !n[0], n[0]), 0, CDTB_GRAN_4K, 3'h6, 6'h0C,
                    0, 0, 1, cdtb_world_t'(k), 0, 52'h0000000001000, 4'h0,
                    {!n[0], e2});
            end
        end
        req(mk(48'h000000000100, 0, 0, 0, 0), 0, CDTB_GRAN_4K, 3'h6, 6'h0C, 0, 0, 0,
            CDTB_WORLD_NS_EL1, 0, 52'h0000000001000, 4'h0, 2'b11);
        end_sim();
    end
endmodule // tb_cdtb_decode
